// *** pkg/led_pkg.sv ***
// Register map, field positions and timing counts of the status indicator driver
package led_pkg;
  localparam logic [7:0] second_indicator_pin_select_control_addr = 8'h00;
  localparam logic [7:0] event_input_addr = 8'h04;
  localparam logic [31:0] second_indicator_pin_reset_value = 32'h00000088;
  localparam logic [31:0] second_indicator_pin_write_mask = 32'h000060ff;
  localparam int collision_bit = 0;
  localparam int jabber_bit = 1;
  localparam int receive_bit = 2;
  localparam int polarity_rev_bit = 3;
  localparam int transmit_bit = 4;
  localparam int matched_bit = 5;
  localparam int link_bit = 6;
  localparam int stretch_bit = 7;
  localparam int disable_bit = 13;
  localparam int polarity_bit = 14;
  localparam int state_bit = 15;
  localparam int num_events = 7;
  localparam int clk_mhz = 100;
  localparam int heartbeat_ns = 4000;
  localparam int heartbeat_cycles = heartbeat_ns * clk_mhz / 1000;
  localparam int stretch_ms = 50;
  localparam int stretch_cycles = stretch_ms * clk_mhz * 1000;
  localparam int timer_width = 24;
endpackage : led_pkg

// *** pkg/event_if.sv ***
// Events and enables passed between the indicator top and its combiner
`timescale 1ns/100ps
`default_nettype none
interface event_if;
  logic [led_pkg::num_events-1:0] raw;
  logic [led_pkg::num_events-1:0] enable;
  logic combined;
  modport src (output raw, output enable, input combined);
  modport comb (input raw, input enable, output combined);
endinterface : event_if
`default_nettype wire

// *** rtl/event_combiner.sv ***
// OR of the enabled indicator events
`timescale 1ns/100ps
`default_nettype none
module event_combiner (
  event_if.comb ev // Events, enables and combined result
);
  genvar i;
  logic [led_pkg::num_events-1:0] gated;
  generate
    for (i = 0; i < led_pkg::num_events; i++) begin : g_gate
      assign gated[i] = ev.raw[i] & ev.enable[i]; // [R1] [R2] [R17] [R18] [R20] [R21] [R22]
    end
  endgenerate
  assign ev.combined = |gated; // [R4]
endmodule : event_combiner
`default_nettype wire

// *** rtl/heartbeat_mask.sv ***
// Blanks collision during the heartbeat window after a transmit ends on the attachment port
`timescale 1ns/100ps
`default_nettype none
module heartbeat_mask #(
  parameter int window_cycles = led_pkg::heartbeat_cycles // Window length
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic aui_selected, // Attachment port in use
  input wire logic transmit_active, // Transmit in progress
  input wire logic collision_in, // Raw collision
  output logic collision_out // Collision after blanking
);
  logic [15:0] cnt_q, cnt_d;
  logic tx_q, tx_d;
  always_comb begin
    tx_d = transmit_active;
    cnt_d = cnt_q;
    if (tx_q && !transmit_active) begin
      cnt_d = 16'(window_cycles);
    end else if (cnt_q != 16'h0000) begin
      cnt_d = cnt_q - 16'h0001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      tx_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tx_q <= tx_d;
    end
  end
  assign collision_out = collision_in & ~(aui_selected & (cnt_q != 16'h0000)); // [R3]
  a_window_blanks: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_q && !transmit_active && aui_selected) |=> !collision_out) // [R3]
    else $error("collision passed in heartbeat window");
  c_window: cover property (@(posedge pclk) disable iff (!presetn)
    aui_selected && collision_in && !collision_out);
endmodule : heartbeat_mask
`default_nettype wire

// *** rtl/status_led_driver.sv ***
// Second status indicator pin driver with its APB control register
//
// Overview of operation
// [R1] Bit 1 enables jabber event
// [R2] Bit 0 enables collision event
// [R3] Attachment port: blank collision after transmit
// [R4] Indicator is OR of enabled events
// [R5] Hard reset loads 0088h
// [R6] Soft reset and stop keep register
// [R7] Bits 31-16 reserved, write zero
// [R8] Bits 12-8 reserved, write zero
// [R9] Bit 15 shows unstretched combined state
// [R10] Bit 15 read-only, always live
// [R11] Software trusts bit 15 only on link pass
// [R12] Polarity one: totem pole, high active
// [R13] Polarity zero: open drain, low active
// [R14] Polarity affects only the pin
// [R15] Bit 13 floats the pin
// [R16] Bit 7 enables pulse stretcher
// [R17] Bit 6 enables link pass event
// [R18] Bit 5 enables address-matched receive event
// [R19] Default selects polarity reversed, stretched
// [R20] Bit 4 enables transmit event
// [R21] Bit 3 enables receive polarity reversed event
// [R22] Bit 2 enables receive event
// [R23] Stretcher restarts on each rising edge
`timescale 1ns/100ps
`default_nettype none
module status_led_driver #(
  parameter int stretch_cycles = led_pkg::stretch_cycles // Stretch length in cycles
) (
  input wire logic pclk, // APB clock, 100 MHz
  input wire logic presetn, // Hard reset, async, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic jabber_in, // Jabber condition
  input wire logic collision_in, // Collision activity
  input wire logic receive_in, // Receive activity
  input wire logic receive_polarity_reversed, // Receive pair reversed
  input wire logic transmit_in, // Transmit activity
  input wire logic matched_receive_in, // Address-filtered receive
  input wire logic link_pass_flag, // Twisted-pair link pass
  input wire logic aui_selected, // Attachment port selected
  output logic second_indicator_pin_o, // Pin output level
  output logic second_indicator_pin_oe // Pin output enable
);
  logic [6:0] ev_meta_q, ev_sync_q;
  logic aui_meta_q, aui_sync_q;
  logic [15:0] ctrl_q, ctrl_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic comb_q;
  logic comb_prev_q;
  logic [led_pkg::timer_width-1:0] timer_q, timer_d;
  logic pin_o_q, pin_o_d;
  logic pin_oe_q, pin_oe_d;
  logic coll_blanked;
  logic access;
  logic hit_ctrl;
  logic hit_event;
  logic lit;
  event_if ev ();

  // Event pins come from other blocks' domains; two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_meta_q <= 7'h00;
      ev_sync_q <= 7'h00;
      aui_meta_q <= 1'b0;
      aui_sync_q <= 1'b0;
    end else begin
      ev_meta_q <= {link_pass_flag, matched_receive_in, transmit_in,
                    receive_polarity_reversed, receive_in, jabber_in, collision_in};
      ev_sync_q <= ev_meta_q;
      aui_meta_q <= aui_selected;
      aui_sync_q <= aui_meta_q;
    end
  end

  heartbeat_mask u_hb (
    .pclk(pclk),
    .presetn(presetn),
    .aui_selected(aui_sync_q),
    .transmit_active(ev_sync_q[led_pkg::transmit_bit]),
    .collision_in(ev_sync_q[led_pkg::collision_bit]),
    .collision_out(coll_blanked)
  );

  assign ev.raw = {ev_sync_q[6:1], coll_blanked};
  assign ev.enable = ctrl_q[6:0];

  event_combiner u_comb (
    .ev(ev.comb)
  );

  assign access = psel & penable;
  assign hit_ctrl = (paddr == led_pkg::second_indicator_pin_select_control_addr);
  assign hit_event = (paddr == led_pkg::event_input_addr);

  // Register and bus answer; zero wait states
  always_comb begin
    ctrl_d = ctrl_q;
    prdata_d = prdata_q;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      pready_d = 1'b1;
      pslverr_d = !(hit_ctrl || hit_event);
      if (hit_ctrl) begin
        prdata_d = {16'h0000, comb_q, ctrl_q[14:0]}; // [R9] [R10] [R14] [R7] [R8]
      end else if (hit_event) begin
        prdata_d = {25'h0000000, ev_sync_q};
      end else begin
        prdata_d = 32'h00000000;
      end
    end
    if (access && pready_q && pwrite && hit_ctrl) begin
      ctrl_d = pwdata[15:0] & led_pkg::second_indicator_pin_write_mask[15:0]; // [R7] [R8] [R10]
    end
  end

  // Pulse stretcher and pin drive
  always_comb begin
    timer_d = timer_q;
    if (ev.combined && !comb_prev_q) begin
      timer_d = led_pkg::timer_width'(stretch_cycles); // [R23]
    end else if (timer_q != '0) begin
      timer_d = timer_q - 1'b1;
    end
    lit = comb_q | (ctrl_q[led_pkg::stretch_bit] & (timer_q != '0)); // [R16]
    if (ctrl_q[led_pkg::disable_bit]) begin
      pin_o_d = 1'b0;
      pin_oe_d = 1'b0; // [R15]
    end else if (ctrl_q[led_pkg::polarity_bit]) begin
      pin_o_d = lit;
      pin_oe_d = 1'b1; // [R12]
    end else begin
      pin_o_d = 1'b0;
      pin_oe_d = lit; // [R13]
    end
  end

  // Only the hard reset touches the control word; no soft reset input exists here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= led_pkg::second_indicator_pin_reset_value[15:0]; // [R5] [R6] [R19]
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      comb_q <= 1'b0;
      comb_prev_q <= 1'b0;
      timer_q <= '0;
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      comb_q <= ev.combined; // [R4] [R9]
      comb_prev_q <= ev.combined;
      timer_q <= timer_d;
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign second_indicator_pin_o = pin_o_q;
  assign second_indicator_pin_oe = pin_oe_q;

  a_state_tracks: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 comb_q == $past(ev.combined)) // [R9]
    else $error("combined state bit not tracking events");
  a_float_disable: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl_q[13]) |-> !second_indicator_pin_oe) // [R15]
    else $error("pin driven while disabled");
  a_totem_drive: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(ctrl_q[14]) && !$past(ctrl_q[13])) |->
      (second_indicator_pin_oe && second_indicator_pin_o == $past(lit))) // [R12]
    else $error("totem pole drive wrong");
  a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
    (!$past(ctrl_q[14]) && !$past(ctrl_q[13])) |->
      (!second_indicator_pin_o && second_indicator_pin_oe == $past(lit))) // [R13]
    else $error("open drain drive wrong");
  a_no_stretch: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[7] |-> (lit == comb_q)) // [R16]
    else $error("stretch active while disabled");
  a_stretch_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[7] && $rose(comb_q) && stretch_cycles > 2) ##1 ctrl_q[7] |-> lit) // [R23]
    else $error("stretch did not hold indicator");
  a_write_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pready && pwrite && hit_ctrl) |=>
      ctrl_q == ($past(pwdata[15:0]) & 16'h60ff)) // [R8]
    else $error("control write not masked");
  a_read_state: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && hit_ctrl) |=>
      (prdata[15] == $past(comb_q) && prdata[31:16] == 16'h0000)) // [R14]
    else $error("read of combined state wrong");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !hit_ctrl && !hit_event) |=> (pready && pslverr))
    else $error("unmapped access not flagged");
  // Bit 15 and the reserved fields never hold written data, so reads stay live
  a_reserved_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[15] == 1'b0 && ctrl_q[12:8] == 5'h00)) // [R10]
    else $error("reserved or status bit stored");
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_error_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pready && pslverr) |=> $stable(ctrl_q))
    else $error("refused access changed control");
  c_write: cover property (@(posedge pclk) access && pready && pwrite && hit_ctrl);
  c_lit_open: cover property (@(posedge pclk) second_indicator_pin_oe && !ctrl_q[14]);
  c_lit_totem: cover property (@(posedge pclk) second_indicator_pin_o && ctrl_q[14]);
  c_stretch: cover property (@(posedge pclk) lit && !comb_q);
endmodule : status_led_driver
`default_nettype wire

// *** sim/led_indicator_model.sv ***
// External indicator and pull-up resistor on the second status pin
`timescale 1ns/100ps
`default_nettype none
module led_indicator_model (
  input wire logic pin_o, // Level driven by the device
  input wire logic pin_oe, // Device drives the pin
  output logic pad // Resolved pad level
);
  // A released pin floats high through the pull-up, never to the last driven value
  assign pad = pin_oe ? pin_o : 1'b1;
endmodule : led_indicator_model
`default_nettype wire

// *** sim/network_status_led_driver_bench.sv ***
// Self-checking bench of the second status indicator driver
`timescale 1ns/100ps
`default_nettype none
module network_status_led_driver_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [6:0] ev = 7'h00;
  logic aui = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic pin_o;
  logic pin_oe;
  logic pad;
  logic [64:0] exp_q[$];
  logic [64:0] e;
  int fails = 0;
  int total_checks = 0;
  int seed = 72518;
  always #5 pclk = ~pclk;
  // Short stretch keeps the run brief; expectations use the same 20 cycles
  status_led_driver #(.stretch_cycles(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .jabber_in(ev[1]), .collision_in(ev[0]),
    .receive_in(ev[2]), .receive_polarity_reversed(ev[3]), .transmit_in(ev[4]),
    .matched_receive_in(ev[5]), .link_pass_flag(ev[6]), .aui_selected(aui),
    .second_indicator_pin_o(pin_o), .second_indicator_pin_oe(pin_oe));
  led_indicator_model led (.pin_o(pin_o), .pin_oe(pin_oe), .pad(pad));
  task summarize;
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task chk(input logic ok);
    total_checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("ERROR %0t result differs from expectation", $time);
    end
  endtask : chk
  // Answers are matched in order against the notes left by the apb task
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) chk(1'b0);
      else begin
        e = exp_q.pop_front();
        chk(((prdata & e[63:32]) === (e[31:0] & e[63:32])) && (pslverr === e[64]));
      end
    end
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
    input logic er);
    int n;
    n = 0;
    exp_q.push_back({er, m, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task pin(input logic p, input logic oe);
    chk(pad === p && pin_oe === oe);
  endtask : pin
  initial begin
    logic [6:0] v;
    logic [31:0] x;
    cyc(3);
    presetn <= 1'b1;
    cyc(1);
    apb(1'b0, 8'h00, 32'h00000088, 32'hffffffff, 1'b0);
    apb(1'b1, 8'h00, 32'h000060ff, 32'h0, 1'b0);
    apb(1'b0, 8'h00, 32'h000060ff, 32'hffffffff, 1'b0);
    apb(1'b1, 8'h08, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h0c, 32'h0, 32'hffffffff, 1'b1);
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 2; k++) begin
        v = 7'($random(seed));
        // Bit 15 is only trusted with the link in pass state
        if (i != 6) v[6] = 1'b1;
        v[i] = k[0];
        x = 32'h4000 | (32'h1 << i);
        apb(1'b1, 8'h00, x, 32'h0, 1'b0);
        ev <= v;
        cyc(6);
        apb(1'b0, 8'h00, x | (32'(k) << 15), 32'hffffffff, 1'b0);
        apb(1'b0, 8'h04, {25'h0, v}, 32'h7f, 1'b0);
        pin(k[0], 1'b1);
      end
    end
    apb(1'b1, 8'h00, 32'h407f, 32'h0, 1'b0);
    repeat (4) begin
      v = 7'($random(seed));
      ev <= v;
      cyc(6);
      apb(1'b0, 8'h00, {16'h0, |v, 15'h407f}, 32'hffffffff, 1'b0);
    end
    apb(1'b1, 8'h00, 32'h0004, 32'h0, 1'b0);
    ev <= 7'h04;
    cyc(6);
    pin(1'b0, 1'b1);
    apb(1'b0, 8'h00, 32'h8004, 32'hffffffff, 1'b0);
    ev <= 7'h00;
    cyc(6);
    pin(1'b1, 1'b0);
    apb(1'b1, 8'h00, 32'h6004, 32'h0, 1'b0);
    ev <= 7'h04;
    cyc(6);
    pin(1'b1, 1'b0);
    // Second pulse lands before the first stretch ends; the check lands after it would have ended without a restart
    apb(1'b1, 8'h00, 32'h4084, 32'h0, 1'b0);
    ev <= 7'h00;
    cyc(6);
    ev <= 7'h04;
    cyc(1);
    ev <= 7'h00;
    cyc(12);
    ev <= 7'h04;
    cyc(1);
    ev <= 7'h00;
    cyc(14);
    pin(1'b1, 1'b1);
    apb(1'b0, 8'h00, 32'h4084, 32'hffffffff, 1'b0);
    cyc(30);
    pin(1'b0, 1'b1);
    apb(1'b1, 8'h00, 32'h4001, 32'h0, 1'b0);
    aui <= 1'b1;
    ev <= 7'h10;
    cyc(5);
    ev <= 7'h00;
    cyc(20);
    ev <= 7'h01;
    cyc(6);
    pin(1'b0, 1'b1);
    cyc(led_pkg::heartbeat_cycles);
    pin(1'b1, 1'b1);
    cyc(4);
    chk(exp_q.size() == 0);
    summarize();
  end
endmodule : network_status_led_driver_bench
`default_nettype wire
